// ==== rtl/ers_consts.vh ====
`ifndef ERS_CONSTS_VH
`define ERS_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define ERS_IDX_PAGE_SEL 5'h00
`define ERS_IDX_IRQ_STAT 5'h02
`define ERS_IDX_IRQ_MASK 5'h03
`define ERS_IDX_SYNC_STATE 5'h10
`define ERS_IDX_ALARM_ONE 5'h11
`define ERS_IDX_TIMER_STATE 5'h12
`define ERS_IDX_PHASE_HIGH 5'h13
`define ERS_IDX_PHASE_LOW 5'h14
`define ERS_IDX_FA_PATTERN 5'h15
`define ERS_IDX_SIGNAL_STATE 5'h16
`define ERS_IDX_JITTER_STATE 5'h17
`define ERS_IDX_NFA_PATTERN 5'h18
`define ERS_IDX_MF_PATTERN 5'h19
`define ERS_IDX_UNUSED_1A 5'h1A
`define ERS_IDX_ALARM_TWO 5'h1B
`define ERS_IDX_UNUSED_1C 5'h1C
`define ERS_IDX_UNUSED_1E 5'h1E
`define ERS_IDX_PART_IDENT 5'h1F

// ----------------------------------------------------------------
// Page selection
// ----------------------------------------------------------------
`define ERS_PAGE_W 3
`define ERS_PAGE_STATUS 3'h3
`define ERS_PAGE_RESET 3'h0

// ----------------------------------------------------------------
// Synchronization status word bit positions
// ----------------------------------------------------------------
`define ERS_SYNC_BASIC_LOSS 7
`define ERS_SYNC_MF_LOSS 6
`define ERS_SYNC_CRC4_LOSS 5
`define ERS_SYNC_EBIT_FIRST 4
`define ERS_SYNC_EBIT_SECOND 3
`define ERS_SYNC_CRC4_TIMEOUT 2
`define ERS_SYNC_PROLONGED 1
`define ERS_SYNC_INTERWORK 0

// ----------------------------------------------------------------
// Interrupt status / mask bit positions
// ----------------------------------------------------------------
`define ERS_IRQ_W 4
`define ERS_IRQ_CRC4_TIMEOUT 0
`define ERS_IRQ_PROLONGED 1
`define ERS_IRQ_BASIC_LOST 2
`define ERS_IRQ_CRC4_LOST 3
`define ERS_IRQ_RESET 4'h0

// ----------------------------------------------------------------
// Timing, counted in 125 us receive frames
// ----------------------------------------------------------------
`define ERS_FRAME_US 125
`define ERS_CRC4_WINDOW_US 8000
`define ERS_PROLONGED_US 100000
`define ERS_CRC4_WINDOW_FRAMES (`ERS_CRC4_WINDOW_US / `ERS_FRAME_US)
`define ERS_PROLONGED_FRAMES (`ERS_PROLONGED_US / `ERS_FRAME_US)
`define ERS_CRC4_CNT_W 7
`define ERS_PROLONGED_CNT_W 10

`endif

// ==== rtl/ers_sync_status_bank.v ====
// Contract
// - Status registers on page three, five-bit offset
// - Sync, alarm one, timer, phase words mapped
// - Alignment, signal, jitter patterns at 15H-19H
// - 1AH, 1CH-1EH unused; alarm two at 1BH
// - Bit 7 high while basic alignment lost
// - Bit 6 high while multiframe alignment lost
// - Bit 5 high while CRC-4 alignment lost
// - Bits 4,3 hold last multiframe E-bits
// - Bit 2 set: no CRC-4 within 8 ms
// - Timeout forces reframe if maintenance, no interworking
// - Bit 1 set after 100 ms basic loss
// - Prolonged loss alarm clears on realignment
// - Bit 0 shows CRC-4 interworking state
//
// Our own choice: the APB register port.
`include "ers_consts.vh"

module ers_sync_status_bank #(
    // Arbitrary identification value
    parameter [7:0] PART_IDENT_CODE = 8'h5A
) (
    // Clock and reset
    input wire CLK,
    input wire RESET_N,
    // APB slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // Receive framer state
    input wire FRAME_TICK,
    input wire BASIC_ALIGN_OK,
    input wire MULTIFRAME_ALIGN_OK,
    input wire CRC4_ALIGN_OK,
    input wire EBIT_STROBE,
    input wire RX_EBIT_FIRST_IN,
    input wire RX_EBIT_SECOND_IN,
    input wire CRC4_INTERWORK_IN,
    input wire MAINT_OPTION,
    input wire AUTO_INTERWORK_EN,
    // Other status words from the framer
    input wire [7:0] ALARM_ONE_IN,
    input wire [7:0] TIMER_STATE_IN,
    input wire [7:0] PHASE_HIGH_IN,
    input wire [7:0] PHASE_LOW_IN,
    input wire [7:0] FA_PATTERN_IN,
    input wire [7:0] SIGNAL_STATE_IN,
    input wire [7:0] JITTER_STATE_IN,
    input wire [7:0] NFA_PATTERN_IN,
    input wire [7:0] MF_PATTERN_IN,
    input wire [7:0] ALARM_TWO_IN,
    // Framer control and interrupt
    output reg FORCE_REFRAME,
    output wire IRQ
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg [`ERS_PAGE_W-1:0] page_r;
    reg [`ERS_IRQ_W-1:0] irq_stat_r;
    wire [`ERS_IRQ_W-1:0] irq_stat_nxt;
    reg [`ERS_IRQ_W-1:0] irq_mask_r;
    reg [`ERS_IRQ_W-1:0] irq_set;
    reg err_r;
    reg rx_ebit_first_r;
    reg rx_ebit_second_r;
    reg crc4_search_timeout_r;
    reg prolonged_frame_loss_alarm_r;
    reg [`ERS_CRC4_CNT_W-1:0] crc4_cnt_r;
    reg [`ERS_PROLONGED_CNT_W-1:0] loss_cnt_r;
    reg basic_ok_d_r;
    reg crc4_ok_d_r;
    reg [7:0] rd_val;
    reg rd_err;
    reg rx_ebit_first_nxt;
    reg rx_ebit_second_nxt;
    reg [`ERS_CRC4_CNT_W-1:0] crc4_cnt_nxt;
    reg crc4_search_timeout_nxt;
    reg force_reframe_nxt;
    reg [`ERS_PROLONGED_CNT_W-1:0] loss_cnt_nxt;
    reg prolonged_frame_loss_alarm_nxt;
    reg [`ERS_PAGE_W-1:0] page_nxt;
    reg [`ERS_IRQ_W-1:0] irq_mask_nxt;
    reg [31:0] prdata_nxt;
    reg err_nxt;
    wire page_wr;
    wire mask_wr;
    wire stat_wr;
    wire [4:0] idx;
    wire setup_ph;
    wire wr_acc;
    wire multiframe_loss;
    wire crc4_multiframe_loss;
    wire crc4_interwork_state;
    wire [7:0] sync_state_word;
    wire crc4_expire;
    wire loss_expire;

    assign idx = PADDR[6:2];
    assign setup_ph = PSEL & ~PENABLE;
    assign wr_acc = PSEL & PENABLE & PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = err_r & PSEL & PENABLE;

    // ----------------------------------------------------------------
    // Synchronization status word
    // ----------------------------------------------------------------
    // multiframe loss flag
    assign multiframe_loss = ~MULTIFRAME_ALIGN_OK;
    assign crc4_multiframe_loss = ~CRC4_ALIGN_OK;
    assign crc4_interwork_state = CRC4_INTERWORK_IN;

    assign sync_state_word = {~BASIC_ALIGN_OK,
                              multiframe_loss,
                              crc4_multiframe_loss,
                              rx_ebit_first_r,
                              rx_ebit_second_r,
                              crc4_search_timeout_r,
                              prolonged_frame_loss_alarm_r,
                              crc4_interwork_state};

    always @* begin
        rx_ebit_first_nxt = rx_ebit_first_r;
        rx_ebit_second_nxt = rx_ebit_second_r;
        if (EBIT_STROBE) begin
            rx_ebit_first_nxt = RX_EBIT_FIRST_IN;
            rx_ebit_second_nxt = RX_EBIT_SECOND_IN;
        end
    end

    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_ebit_first_r <= 1'b0;
            rx_ebit_second_r <= 1'b0;
        end else begin
            rx_ebit_first_r <= rx_ebit_first_nxt;
            rx_ebit_second_r <= rx_ebit_second_nxt;
        end
    end

    // ----------------------------------------------------------------
    // CRC-4 search window
    // ----------------------------------------------------------------
    // window expires on 64th frame
    assign crc4_expire = FRAME_TICK & BASIC_ALIGN_OK & CRC4_ALIGN_OK == 1'b0
                         & ~crc4_search_timeout_r
                         & (crc4_cnt_r == (`ERS_CRC4_WINDOW_FRAMES - 1));

    always @* begin
        crc4_cnt_nxt = crc4_cnt_r;
        crc4_search_timeout_nxt = crc4_search_timeout_r;
        force_reframe_nxt = 1'b0;
        if (!BASIC_ALIGN_OK || CRC4_ALIGN_OK) begin
            // Window restarts at next basic alignment
            crc4_cnt_nxt = {`ERS_CRC4_CNT_W{1'b0}};
            crc4_search_timeout_nxt = 1'b0;
        end else if (crc4_expire) begin
            crc4_search_timeout_nxt = 1'b1;
            force_reframe_nxt = MAINT_OPTION & ~AUTO_INTERWORK_EN;
        end else if (FRAME_TICK && !crc4_search_timeout_r) begin
            crc4_cnt_nxt = crc4_cnt_r + 1'b1;
        end
    end

    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            crc4_cnt_r <= {`ERS_CRC4_CNT_W{1'b0}};
            crc4_search_timeout_r <= 1'b0;
            FORCE_REFRAME <= 1'b0;
        end else begin
            crc4_cnt_r <= crc4_cnt_nxt;
            crc4_search_timeout_r <= crc4_search_timeout_nxt;
            FORCE_REFRAME <= force_reframe_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Prolonged basic frame loss
    // ----------------------------------------------------------------
    // alarm on 800th lost frame
    assign loss_expire = FRAME_TICK & ~BASIC_ALIGN_OK & ~prolonged_frame_loss_alarm_r
                         & (loss_cnt_r == (`ERS_PROLONGED_FRAMES - 1));

    always @* begin
        loss_cnt_nxt = loss_cnt_r;
        prolonged_frame_loss_alarm_nxt = prolonged_frame_loss_alarm_r;
        if (BASIC_ALIGN_OK) begin
            loss_cnt_nxt = {`ERS_PROLONGED_CNT_W{1'b0}};
            prolonged_frame_loss_alarm_nxt = 1'b0;
        end else if (loss_expire) begin
            prolonged_frame_loss_alarm_nxt = 1'b1;
        end else if (FRAME_TICK && !prolonged_frame_loss_alarm_r) begin
            loss_cnt_nxt = loss_cnt_r + 1'b1;
        end
    end

    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            loss_cnt_r <= {`ERS_PROLONGED_CNT_W{1'b0}};
            prolonged_frame_loss_alarm_r <= 1'b0;
        end else begin
            loss_cnt_r <= loss_cnt_nxt;
            prolonged_frame_loss_alarm_r <= prolonged_frame_loss_alarm_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt events
    // ----------------------------------------------------------------
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            basic_ok_d_r <= 1'b0;
            crc4_ok_d_r <= 1'b0;
        end else begin
            basic_ok_d_r <= BASIC_ALIGN_OK;
            crc4_ok_d_r <= CRC4_ALIGN_OK;
        end
    end

    always @* begin
        irq_set = {`ERS_IRQ_W{1'b0}};
        irq_set[`ERS_IRQ_CRC4_TIMEOUT] = crc4_expire & BASIC_ALIGN_OK & ~CRC4_ALIGN_OK;
        irq_set[`ERS_IRQ_PROLONGED] = loss_expire;
        irq_set[`ERS_IRQ_BASIC_LOST] = basic_ok_d_r & ~BASIC_ALIGN_OK;
        irq_set[`ERS_IRQ_CRC4_LOST] = crc4_ok_d_r & ~CRC4_ALIGN_OK;
    end

    // Write strobes, low half of the map only
    assign page_wr = wr_acc & ~PADDR[7] & (idx == `ERS_IDX_PAGE_SEL);
    assign mask_wr = wr_acc & ~PADDR[7] & (idx == `ERS_IDX_IRQ_MASK);
    assign stat_wr = wr_acc & ~PADDR[7] & (idx == `ERS_IDX_IRQ_STAT);

    // Sticky status per bit; set wins over a clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < `ERS_IRQ_W; g = g + 1) begin : g_irq
            assign irq_stat_nxt[g] = (irq_stat_r[g] & ~(stat_wr & PWDATA[g])) | irq_set[g];
        end
    endgenerate

    assign IRQ = |(irq_stat_r & irq_mask_r);

    // ----------------------------------------------------------------
    // Writable registers
    // ----------------------------------------------------------------
    always @* begin
        page_nxt = page_r;
        irq_mask_nxt = irq_mask_r;
        // only page, mask and status clear are writable
        if (page_wr) begin
            page_nxt = PWDATA[`ERS_PAGE_W-1:0];
        end
        if (mask_wr) begin
            irq_mask_nxt = PWDATA[`ERS_IRQ_W-1:0];
        end
    end

    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            page_r <= `ERS_PAGE_RESET;
            irq_mask_r <= `ERS_IRQ_RESET;
            irq_stat_r <= `ERS_IRQ_RESET;
        end else begin
            page_r <= page_nxt;
            irq_mask_r <= irq_mask_nxt;
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    always @* begin
        rd_val = 8'h00;
        rd_err = 1'b0;
        if (PADDR[7]) begin
            rd_err = 1'b1;
        end else if (idx == `ERS_IDX_PAGE_SEL) begin
            rd_val = {{(8-`ERS_PAGE_W){1'b0}}, page_r};
        end else if (idx == `ERS_IDX_IRQ_STAT) begin
            rd_val = {{(8-`ERS_IRQ_W){1'b0}}, irq_stat_r};
        end else if (idx == `ERS_IDX_IRQ_MASK) begin
            rd_val = {{(8-`ERS_IRQ_W){1'b0}}, irq_mask_r};
        end else if (idx[4] == 1'b0) begin
            rd_err = 1'b1;
        // status page needs page three selected
        end else if (page_r != `ERS_PAGE_STATUS) begin
            rd_val = 8'h00;
        // sync, alarm, timer and phase words
        end else if (idx == `ERS_IDX_SYNC_STATE) begin
            rd_val = sync_state_word;
        end else if (idx == `ERS_IDX_ALARM_ONE) begin
            rd_val = ALARM_ONE_IN;
        end else if (idx == `ERS_IDX_TIMER_STATE) begin
            rd_val = TIMER_STATE_IN;
        end else if (idx == `ERS_IDX_PHASE_HIGH) begin
            rd_val = PHASE_HIGH_IN;
        end else if (idx == `ERS_IDX_PHASE_LOW) begin
            rd_val = PHASE_LOW_IN;
        end else if (idx == `ERS_IDX_FA_PATTERN) begin
            rd_val = FA_PATTERN_IN;
        end else if (idx == `ERS_IDX_SIGNAL_STATE) begin
            rd_val = SIGNAL_STATE_IN;
        end else if (idx == `ERS_IDX_JITTER_STATE) begin
            rd_val = JITTER_STATE_IN;
        end else if (idx == `ERS_IDX_NFA_PATTERN) begin
            rd_val = NFA_PATTERN_IN;
        end else if (idx == `ERS_IDX_MF_PATTERN) begin
            rd_val = MF_PATTERN_IN;
        // alarm two; unused offsets read zero
        end else if (idx == `ERS_IDX_ALARM_TWO) begin
            rd_val = ALARM_TWO_IN;
        end else if (idx == `ERS_IDX_PART_IDENT) begin
            rd_val = PART_IDENT_CODE;
        end else begin
            rd_val = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // APB answer, captured in the setup cycle
    // ----------------------------------------------------------------
    always @* begin
        prdata_nxt = PRDATA;
        err_nxt = err_r;
        if (setup_ph) begin
            prdata_nxt = PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_val};
            err_nxt = rd_err;
        end
    end

    // Answer holds through the access phase
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PRDATA <= 32'h0000_0000;
            err_r <= 1'b0;
        end else begin
            PRDATA <= prdata_nxt;
            err_r <= err_nxt;
        end
    end

endmodule

// ==== tb/ers_line_model.sv ====
module ers_line_model (
    // Clock and reset
    input logic CLK,
    input logic RESET_N,
    // Control
    input logic run,
    // Frame timing and E-bits
    output logic tick,
    output logic ebit_strobe,
    output logic ebit_first,
    output logic ebit_second
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_r;
    logic [3:0] frm_r;
    logic [1:0] cap_r;
    // Lines carry the inverse outside the strobe, so a late capture shows
    assign {ebit_first, ebit_second} = ebit_strobe ? cap_r : ~cap_r;
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_r <= 2'h0;
            frm_r <= 4'h0;
            cap_r <= 2'h0;
            tick <= 1'b0;
            ebit_strobe <= 1'b0;
        end else begin
            div_r <= run ? div_r + 2'h1 : 2'h0;
            tick <= run && div_r == 2'h3;
            ebit_strobe <= tick && frm_r == 4'hF;
            frm_r <= tick ? frm_r + 4'h1 : frm_r;
            cap_r <= (tick && frm_r == 4'hF) ? 2'($urandom_range(3)) : cap_r;
        end
    end
endmodule

// ==== tb/ers_properties.sv ====
module ers_properties (
    // Clock and reset
    input logic CLK,
    input logic RESET_N,
    // Register bus
    input logic PSEL,
    input logic PENABLE,
    input logic PWRITE,
    input logic [7:0] PADDR,
    input logic [31:0] PRDATA,
    input logic PSLVERR,
    // Framer side
    input logic FRAME_TICK,
    input logic BASIC_ALIGN_OK,
    input logic CRC4_ALIGN_OK,
    input logic MAINT_OPTION,
    input logic AUTO_INTERWORK_EN,
    input logic FORCE_REFRAME
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_acc;
        PSEL && PENABLE;
    endsequence
    sequence s_rd;
        PSEL && !PENABLE && !PWRITE ##1 PSEL && PENABLE;
    endsequence
    a_refr_gate: assert property (FORCE_REFRAME |->
        $past(FRAME_TICK && MAINT_OPTION && !AUTO_INTERWORK_EN)) else $error("reframe without cause");
    a_refr_align: assert property (FORCE_REFRAME |->
        $past(BASIC_ALIGN_OK && !CRC4_ALIGN_OK)) else $error("reframe while not searching");
    a_refr_pulse: assert property (FORCE_REFRAME |=> !FORCE_REFRAME [*8])
        else $error("reframe pulse repeated");
    a_err_unmapped: assert property (s_acc ##0 PADDR[7] |-> PSLVERR)
        else $error("unmapped access without error");
    a_status_noerr: assert property (s_acc ##0 PADDR[7:6] == 2'b01 |-> !PSLVERR)
        else $error("status page access flagged");
    a_err_idle: assert property (!PENABLE |-> !PSLVERR)
        else $error("error outside access phase");
    a_read_upper: assert property (s_rd |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    a_read_basic: assert property (s_rd ##0 PADDR == 8'h40 |->
        !(PRDATA[7] && $past(BASIC_ALIGN_OK))) else $error("basic loss shown while aligned");
    a_read_crc: assert property (s_rd ##0 PADDR == 8'h40 |->
        !(PRDATA[5] && $past(CRC4_ALIGN_OK))) else $error("crc loss shown while aligned");
endmodule

bind ers_sync_status_bank ers_properties u_prop (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .FRAME_TICK(FRAME_TICK), .BASIC_ALIGN_OK(BASIC_ALIGN_OK), .CRC4_ALIGN_OK(CRC4_ALIGN_OK),
    .MAINT_OPTION(MAINT_OPTION), .AUTO_INTERWORK_EN(AUTO_INTERWORK_EN),
    .FORCE_REFRAME(FORCE_REFRAME));

// ==== tb/ers_sync_status_bank_test.sv ====
`define CHK(g, e) check_count++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end

module ers_sync_status_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    // Arbitrary identification value
    localparam [7:0] IDENT = 8'hC3;
    localparam [32:0] ALL = {33{1'b1}};
    localparam [32:0] ERR = 33'h1_0000_0000;
    logic CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic basic = 1, mf = 1, crc = 1, iw = 0, maint = 0, auto_iw = 0, run = 0, seen;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [7:0] sw [10];
    logic [65:0] ent;
    logic [65:0] q [$];
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, tick, strobe, e1, e2, refr, irq;
    int errors = 0, check_count = 0, ticks = 0, n, k, t0;

    ers_sync_status_bank #(.PART_IDENT_CODE(IDENT)) uut (.CLK(CLK), .RESET_N(RESET_N),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FRAME_TICK(tick),
        .BASIC_ALIGN_OK(basic), .MULTIFRAME_ALIGN_OK(mf), .CRC4_ALIGN_OK(crc),
        .EBIT_STROBE(strobe), .RX_EBIT_FIRST_IN(e1), .RX_EBIT_SECOND_IN(e2),
        .CRC4_INTERWORK_IN(iw), .MAINT_OPTION(maint), .AUTO_INTERWORK_EN(auto_iw),
        .ALARM_ONE_IN(sw[0]), .TIMER_STATE_IN(sw[1]), .PHASE_HIGH_IN(sw[2]),
        .PHASE_LOW_IN(sw[3]), .FA_PATTERN_IN(sw[4]), .SIGNAL_STATE_IN(sw[5]),
        .JITTER_STATE_IN(sw[6]), .NFA_PATTERN_IN(sw[7]), .MF_PATTERN_IN(sw[8]),
        .ALARM_TWO_IN(sw[9]), .FORCE_REFRAME(refr), .IRQ(irq));
    ers_line_model lm (.CLK(CLK), .RESET_N(RESET_N), .run(run), .tick(tick),
        .ebit_strobe(strobe), .ebit_first(e1), .ebit_second(e2));

    initial begin
        forever #2 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        ticks <= ticks + (tick ? 1 : 0);
    end
    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    always @(posedge CLK) begin
        if (PSEL && PENABLE && PREADY && q.size() > 0) begin
            ent = q.pop_front();
            `CHK({PSLVERR, PRDATA} & ent[65:33], ent[32:0])
        end
    end

    task close_out;
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic xfer(input [7:0] a, input w, input [31:0] d, input [32:0] e, input [32:0] m);
        int i;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PADDR <= a;
        PWRITE <= w;
        PWDATA <= d;
        q.push_back({m, e & m});
        @(posedge CLK);
        PENABLE <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge CLK);
            if (PREADY === 1'b1) break;
        end
        if (i == 16) begin
            errors++;
            close_out;
        end
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask

    function automatic [7:0] exp_reg(input int i);
        case (i)
            8'h1A, 8'h1C, 8'h1D, 8'h1E: exp_reg = 8'h00;
            8'h1B: exp_reg = sw[9];
            8'h1F: exp_reg = IDENT;
            default: exp_reg = sw[i - 8'h11];
        endcase
    endfunction

    initial begin
        void'($urandom(32'h9c0ad26c));
        foreach (sw[i]) sw[i] = 8'($urandom);
        repeat (4) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        xfer(8'h00, 0, 0, 33'h0, ALL);
        xfer(8'h40, 0, 0, 33'h0, ALL);
        xfer(8'h80, 0, 0, ERR, ALL);
        xfer(8'h04, 1, 32'hFF, ERR, ERR);
        xfer(8'h00, 1, 32'h3, 33'h0, ERR);
        for (n = 8'h11; n < 8'h20; n++) begin
            xfer(8'(n * 4), 1, $urandom, 33'h0, ERR);
            xfer(8'(n * 4), 0, 0, {25'h0, exp_reg(n)}, ALL);
        end
        for (n = 0; n < 16; n++) begin
            {basic, mf, crc, iw} <= 4'(n);
            @(posedge CLK);
            xfer(8'h40, 0, 0, {25'h0, ~basic, ~mf, ~crc, 4'h0, iw}, ALL);
        end
        `CHK(irq, 1'b0)
        xfer(8'h08, 0, 0, 33'hC, ALL);
        xfer(8'h0C, 1, 32'h1, 33'h0, ERR);
        for (n = 0; n < 2; n++) begin
            crc <= 1'b1;
            maint <= 1'b1;
            auto_iw <= n[0];
            @(posedge CLK);
            crc <= 1'b0;
            run <= 1'b1;
            t0 = ticks;
            seen = 1'b0;
            for (k = 0; k < 400 && ticks - t0 < 66; k++) begin
                @(posedge CLK);
                if (refr === 1'b1) begin
                    seen = 1'b1;
                    `CHK(ticks - t0, 64)
                end
            end
            run <= 1'b0;
            repeat (8) @(posedge CLK);
            `CHK(seen, ~n[0])
            xfer(8'h40, 0, 0, {25'h0, ~basic, ~mf, ~crc, lm.cap_r, 2'b10, iw}, ALL);
            `CHK(irq, 1'b1)
            xfer(8'h08, 1, 32'h1, 33'h0, ERR);
            `CHK(irq, 1'b0)
        end
        xfer(8'h0C, 1, 32'h2, 33'h0, ERR);
        basic <= 1'b0;
        run <= 1'b1;
        t0 = ticks;
        for (k = 0; k < 4000 && irq !== 1'b1; k++) @(posedge CLK);
        `CHK(ticks - t0, 800)
        xfer(8'h40, 0, 0, 33'h82, 33'h82);
        basic <= 1'b1;
        run <= 1'b0;
        @(posedge CLK);
        xfer(8'h40, 0, 0, 33'h0, 33'h82);
        xfer(8'h08, 1, 32'hF, 33'h0, ERR);
        xfer(8'h08, 0, 0, 33'h0, ALL);
        `CHK(irq, 1'b0)
        close_out;
    end
endmodule
